/* File: src/psm_cfg.svh */
// register map, field positions, reset values and timing counts of the power state manager
`ifndef PSM_CFG_SVH
`define PSM_CFG_SVH

// register byte offsets
`define PSM_OFS_ACT_CFG    8'h00
`define PSM_OFS_SLP_CFG    8'h04
`define PSM_OFS_SLP_CMD    8'h08
`define PSM_OFS_IRQ_ENA    8'h0C
`define PSM_OFS_NAP_CMP    8'h10
`define PSM_OFS_TRIG_CMP   8'h14
`define PSM_OFS_STATUS     8'h18
`define PSM_OFS_NAP_COUNT  8'h1C

// active_power_config fields
`define PSM_ACT_CUR_BIT    0
`define PSM_ACT_VOLT_BIT   1
`define PSM_ACT_SMALL_BIT  2
`define PSM_ACT_LARGE_BIT  3
`define PSM_ACT_OFFC_BIT   4
`define PSM_ACT_CFG_RESET  5'h00

// sleep_power_config fields
`define PSM_SLP_TGT_LSB    0
`define PSM_SLP_PLAN_LSB   2
`define PSM_SLP_SMALL_BIT  5
`define PSM_SLP_LARGE_BIT  6
`define PSM_SLP_OFFC_BIT   7
`define PSM_SLP_CFG_RESET  8'h20

// status word fields
`define PSM_ST_ARMED_BIT   0
`define PSM_ST_VALID_BIT   1
`define PSM_ST_EXPIRED_BIT 2
`define PSM_ST_MEAS_BIT    3
`define PSM_ST_STATE_LSB   4

// sleep command value and output reset image (full power, converters off)
`define PSM_SLEEP_CMD      8'hA9
`define PSM_PWR_RESET      15'h7FC0

// entry sequence steps
`define PSM_ENTER_STEP_TIMER 2'd1
`define PSM_ENTER_STEP_CLK   2'd2
`define PSM_ENTER_LAST       2'd2

// timing
`define PSM_CLK_KHZ         10000
`define PSM_NAP_TICK_MS     100
`define PSM_NAP_TICK_CYCLES (`PSM_NAP_TICK_MS * `PSM_CLK_KHZ)
`define PSM_STAB_US         100
`define PSM_STAB_CYCLES     ((`PSM_STAB_US * `PSM_CLK_KHZ + 999) / 1000)

`endif

/* File: src/psm_pkg.sv */
// types shared by the power state manager
package psm_pkg;

   typedef enum logic [2:0] {
      ST_ACTIVE,
      ST_ENTER,
      ST_SLEEP,
      ST_WAKE
   } psm_state_e;

   typedef enum logic [1:0] {
      TGT_LOW0,
      TGT_LOW1,
      TGT_ULTRA,
      TGT_OFF
   } psm_target_e;

   // power and clock controls towards the analog side
   typedef struct packed {
      logic host_clk_en;
      logic hp_osc_en;
      logic lin_tx_en;
      logic lin_rx_en;
      logic analog_en;
      logic io_supply_rail;
      logic core_supply_rail;
      logic supply_off_indicator_n;
      logic divided_clock_en;
      logic slow_osc_clock_sel;
      logic cur_adc_en;
      logic volt_adc_en;
      logic bias_cut_small;
      logic bias_cut_large;
      logic offcancel_off;
   } psm_pwr_s;

   // controls towards the digital ADC unit
   typedef struct packed {
      logic       pmu_owns;
      logic       start;
      logic       stop;
      logic [2:0] mode;
   } psm_adc_s;

endpackage

/* File: src/psm_power_state_manager.sv */
// power state manager: full power, low power, ultra low power and off sequencing
//
// Operation
// - full power keeps all clocks running at 10MHz and supplies the host.
// - low power stops host clock, precision oscillator and LIN transmitter.
// - ultra low power also drops host rails and pulls the indicator low.
// - off drops everything except digital supply and LIN receiver.
// - power-down starts only on chip select rising after the command.
// - entry stops converters, takes ADC control, switches to sleep settings.
// - entry stops host clock, oscillator, LIN transmitter; core clock goes slow.
// - enabled interrupt wakes at once, stops measurement, waits, restores host clock.
// - pending interrupt rejects the command or undoes a partial entry.
// - aborted entry before timer clear marks the timer count invalid.
// - after reset full power with both converters powered down.
// - full power converters follow the two converter power bits.
// - active bias cut bits and offset cancellation power-down bit.
// - active configuration survives power-down and is restored on wake.
// - sleep states run the core on slow clock, divided clock stopped.
// - sleep converters powered only while measuring; block drives ADC controls.
// - target field picks the state, plan field picks the measurements.
// - sleep bias bits default to small cut; offset cancel defaults off.
// - entry clears and runs nap timer, trigger timer only for plans.
// - nap timer hit wakes if enabled, else stops; trigger timer continues.
// - nap timer stands still in full power for software to read.
// - duration is 100ms times count plus one when valid.
// - interrupt output is low when any enabled status bit is set.
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "psm_cfg.svh"

module psm_power_state_manager
   import psm_pkg::*;
#(
   parameter int unsigned NAP_TICK_CYCLES = `PSM_NAP_TICK_CYCLES,
   parameter int unsigned TICK_W          = 20,
   parameter int unsigned NAP_W           = 16,
   parameter int unsigned IRQ_W           = 16
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             clk_en,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [7:0]       paddr,
   input  wire logic [31:0]      pwdata,
   output var  logic [31:0]      prdata,
   output var  logic             pready,
   output var  logic             pslverr,
   input  wire logic             spi_csn,
   input  wire logic [IRQ_W-1:0] irq_status,
   input  wire logic             adc_done,
   output var  psm_pwr_s         pwr_ctl,
   output var  psm_adc_s         adc_ctl,
   output var  logic             interrupt_out_n,
   output var  logic             nap_timer_expired
);

   localparam logic [11:0] STAB_LAST = 12'(`PSM_STAB_CYCLES - 1);
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(NAP_TICK_CYCLES - 1);

   psm_state_e        state_reg;
   psm_state_e        state_next;
   psm_target_e       tgt_reg;
   psm_pwr_s          pwr_next;
   psm_adc_s          adc_next;
   logic [1:0]        enter_step_reg;
   logic [11:0]       stab_cnt_reg;
   logic              csn_meta_reg;
   logic              csn_sync_reg;
   logic              csn_prev_reg;
   logic [4:0]        act_cfg_reg;
   logic [7:0]        slp_cfg_reg;
   logic [IRQ_W-1:0]  irq_ena_reg;
   logic [NAP_W-1:0]  nap_cmp_reg;
   logic [NAP_W-1:0]  trig_cmp_reg;
   logic [NAP_W-1:0]  nap_count_reg;
   logic [NAP_W-1:0]  trig_count_reg;
   logic [TICK_W-1:0] presc_reg;
   logic [2:0]        plan_reg;
   logic              cmd_armed_reg;
   logic              nap_run_reg;
   logic              valid_reg;
   logic              meas_active_reg;

   // register decode, one-hot over the eight words
   function automatic logic [7:0] reg_decode(input logic [7:0] addr);
      logic [7:0] hit;
      hit = 8'h00;
      if (addr == `PSM_OFS_ACT_CFG) hit[0] = 1'b1;
      else if (addr == `PSM_OFS_SLP_CFG) hit[1] = 1'b1;
      else if (addr == `PSM_OFS_SLP_CMD) hit[2] = 1'b1;
      else if (addr == `PSM_OFS_IRQ_ENA) hit[3] = 1'b1;
      else if (addr == `PSM_OFS_NAP_CMP) hit[4] = 1'b1;
      else if (addr == `PSM_OFS_TRIG_CMP) hit[5] = 1'b1;
      else if (addr == `PSM_OFS_STATUS) hit[6] = 1'b1;
      else if (addr == `PSM_OFS_NAP_COUNT) hit[7] = 1'b1;
      return hit;
   endfunction

   // bus phases; writes land only at the edge that samples pready
   wire logic       apb_setup = psel & ~penable;
   wire logic       wr_fire   = psel & penable & pwrite & pready;
   wire logic [7:0] sel       = reg_decode(paddr);
   wire logic [7:0] wr_sel    = sel & {8{wr_fire}};

   // status and read selection
   wire logic [31:0] status_word = {25'h000_0000, 3'(state_reg), meas_active_reg,
                                    nap_timer_expired, valid_reg, cmd_armed_reg};
   wire logic [31:0] rd_word =
      sel[0] ? {27'h000_0000, act_cfg_reg} :
      sel[1] ? {24'h00_0000, slp_cfg_reg} :
      sel[3] ? 32'(irq_ena_reg) :
      sel[4] ? 32'(nap_cmp_reg) :
      sel[5] ? 32'(trig_cmp_reg) :
      sel[6] ? status_word :
      sel[7] ? 32'(nap_count_reg) : 32'h0000_0000;

   // event decoding
   wire logic csn_rise   = csn_sync_reg & ~csn_prev_reg;
   wire logic irq_hit    = |(irq_status & irq_ena_reg);
   wire logic go_cmd     = (state_reg == ST_ACTIVE) & csn_rise & cmd_armed_reg;
   wire logic stab_done  = (stab_cnt_reg == STAB_LAST);
   wire logic base_tick  = (state_reg == ST_SLEEP) & (presc_reg == TICK_LAST);
   wire logic nap_tick   = base_tick & nap_run_reg;
   wire logic nap_hit    = nap_tick & (nap_count_reg == nap_cmp_reg);
   wire logic plan_disc  = (plan_reg != 3'h0);
   wire logic plan_all   = (plan_reg >= 3'h2);
   wire logic trig_tick  = base_tick & plan_disc & (tgt_reg != TGT_OFF);
   wire logic trig_hit   = trig_tick & (trig_count_reg == trig_cmp_reg);
   wire logic launch     = trig_hit & ~meas_active_reg & ~irq_hit;
   wire logic timer_step = (state_reg == ST_ENTER) & ~irq_hit &
                           (enter_step_reg == `PSM_ENTER_STEP_TIMER);
   wire logic abort_pre  = (state_reg == ST_ENTER) & irq_hit &
                           (enter_step_reg <= `PSM_ENTER_STEP_TIMER);

   // state transitions
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_ACTIVE: if (go_cmd && !irq_hit) state_next = ST_ENTER;
         ST_ENTER: begin
            if (irq_hit) state_next = ST_WAKE;
            else if (enter_step_reg == `PSM_ENTER_LAST) state_next = ST_SLEEP;
         end
         ST_SLEEP: if (irq_hit) state_next = ST_WAKE;
         ST_WAKE: if (stab_done) state_next = ST_ACTIVE;
         default: state_next = ST_ACTIVE;
      endcase
   end

   // power controls per state; active settings are the base image
   always_comb begin
      pwr_next = psm_pwr_s'(`PSM_PWR_RESET);
      pwr_next.cur_adc_en = act_cfg_reg[`PSM_ACT_CUR_BIT];
      pwr_next.volt_adc_en = act_cfg_reg[`PSM_ACT_VOLT_BIT];
      pwr_next.bias_cut_small = act_cfg_reg[`PSM_ACT_SMALL_BIT];
      pwr_next.bias_cut_large = act_cfg_reg[`PSM_ACT_LARGE_BIT];
      pwr_next.offcancel_off = act_cfg_reg[`PSM_ACT_OFFC_BIT];
      case (state_reg)
         ST_ACTIVE: pwr_next.host_clk_en = 1'b1;
         ST_ENTER: begin
            pwr_next.cur_adc_en = 1'b0;
            pwr_next.volt_adc_en = 1'b0;
            pwr_next.bias_cut_small = slp_cfg_reg[`PSM_SLP_SMALL_BIT];
            pwr_next.bias_cut_large = slp_cfg_reg[`PSM_SLP_LARGE_BIT];
            pwr_next.offcancel_off = ~slp_cfg_reg[`PSM_SLP_OFFC_BIT];
            if (enter_step_reg >= `PSM_ENTER_STEP_CLK) begin
               pwr_next.host_clk_en = 1'b0;
               pwr_next.hp_osc_en = 1'b0;
               pwr_next.lin_tx_en = 1'b0;
            end
         end
         ST_SLEEP: begin
            pwr_next.host_clk_en = 1'b0;
            pwr_next.hp_osc_en = 1'b0;
            pwr_next.lin_tx_en = 1'b0;
            pwr_next.divided_clock_en = 1'b0;
            pwr_next.slow_osc_clock_sel = 1'b1;
            pwr_next.cur_adc_en = meas_active_reg;
            pwr_next.volt_adc_en = meas_active_reg & plan_all;
            pwr_next.bias_cut_small = slp_cfg_reg[`PSM_SLP_SMALL_BIT];
            pwr_next.bias_cut_large = slp_cfg_reg[`PSM_SLP_LARGE_BIT];
            pwr_next.offcancel_off = ~slp_cfg_reg[`PSM_SLP_OFFC_BIT];
            if (tgt_reg == TGT_ULTRA || tgt_reg == TGT_OFF) begin
               pwr_next.io_supply_rail = 1'b0;
               pwr_next.core_supply_rail = 1'b0;
               pwr_next.supply_off_indicator_n = 1'b0;
            end
            if (tgt_reg == TGT_OFF) begin
               pwr_next.analog_en = 1'b0;
               pwr_next.cur_adc_en = 1'b0;
               pwr_next.volt_adc_en = 1'b0;
            end
         end
         ST_WAKE: begin
            pwr_next.host_clk_en = 1'b0;
            pwr_next.divided_clock_en = stab_done;
            pwr_next.slow_osc_clock_sel = ~stab_done;
         end
         default: pwr_next.host_clk_en = 1'b1;
      endcase
   end

   // ADC unit controls; the block owns the converter outside full power
   always_comb begin
      adc_next = '0;
      adc_next.pmu_owns = (state_next != ST_ACTIVE);
      adc_next.start = launch;
      adc_next.stop = (meas_active_reg & (adc_done | irq_hit)) |
                      ((state_reg == ST_ENTER) & (enter_step_reg == 2'd0));
      adc_next.mode = plan_reg;
   end

   // bus slave; answer in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (clk_en) begin
         pready <= apb_setup;
         pslverr <= apb_setup & ~|sel;
         prdata <= apb_setup ? rd_word : 32'h0000_0000;
      end
   end

   // configuration registers, software written
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act_cfg_reg <= `PSM_ACT_CFG_RESET;
         slp_cfg_reg <= `PSM_SLP_CFG_RESET;
         irq_ena_reg <= '0;
         nap_cmp_reg <= '0;
         trig_cmp_reg <= '0;
      end else if (clk_en) begin
         if (wr_sel[0]) act_cfg_reg <= pwdata[4:0];
         if (wr_sel[1]) slp_cfg_reg <= pwdata[7:0];
         if (wr_sel[3]) irq_ena_reg <= pwdata[IRQ_W-1:0];
         if (wr_sel[4]) nap_cmp_reg <= pwdata[NAP_W-1:0];
         if (wr_sel[5]) trig_cmp_reg <= pwdata[NAP_W-1:0];
      end
   end

   // chip select synchroniser and command arming
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         csn_meta_reg <= 1'b1;
         csn_sync_reg <= 1'b1;
         csn_prev_reg <= 1'b1;
         cmd_armed_reg <= 1'b0;
      end else if (clk_en) begin
         csn_meta_reg <= spi_csn;
         csn_sync_reg <= csn_meta_reg;
         csn_prev_reg <= csn_sync_reg;
         if (wr_sel[2]) cmd_armed_reg <= (pwdata[7:0] == `PSM_SLEEP_CMD);
         else if (csn_rise) cmd_armed_reg <= 1'b0;
      end
   end

   // sequencer state, entry steps, settle counter, captured target
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_ACTIVE;
         enter_step_reg <= 2'd0;
         stab_cnt_reg <= 12'h000;
         tgt_reg <= TGT_LOW0;
         plan_reg <= 3'h0;
      end else if (clk_en) begin
         state_reg <= state_next;
         enter_step_reg <= (state_reg == ST_ENTER) ? enter_step_reg + 2'd1 : 2'd0;
         stab_cnt_reg <= (state_reg == ST_WAKE) ? stab_cnt_reg + 12'h001 : 12'h000;
         if (go_cmd) begin
            tgt_reg <= psm_target_e'(slp_cfg_reg[`PSM_SLP_TGT_LSB +: 2]);
            plan_reg <= slp_cfg_reg[`PSM_SLP_PLAN_LSB +: 3];
         end
      end
   end

   // nap timer: one count per 100ms tick while sleeping
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         presc_reg <= '0;
         nap_count_reg <= '0;
         nap_run_reg <= 1'b0;
         valid_reg <= 1'b0;
         nap_timer_expired <= 1'b0;
      end else if (clk_en) begin
         presc_reg <= (state_reg == ST_SLEEP && !base_tick) ? presc_reg + 1'b1 : '0;
         if (timer_step) begin
            nap_count_reg <= '0;
            nap_run_reg <= 1'b1;
            valid_reg <= 1'b1;
            nap_timer_expired <= 1'b0;
         end else if (abort_pre) begin
            valid_reg <= 1'b0;
         end else if (nap_hit) begin
            nap_run_reg <= 1'b0;
            nap_timer_expired <= 1'b1;
         end else if (nap_tick) begin
            nap_count_reg <= nap_count_reg + 1'b1;
         end else if (state_reg == ST_WAKE) begin
            nap_run_reg <= 1'b0;
         end
      end
   end

   // trigger timer and measurement window; runs on after a nap hit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trig_count_reg <= '0;
         meas_active_reg <= 1'b0;
      end else if (clk_en) begin
         if (timer_step) trig_count_reg <= '0;
         else if (trig_hit) trig_count_reg <= '0;
         else if (trig_tick) trig_count_reg <= trig_count_reg + 1'b1;
         // window ends on done or wake
         if (state_reg != ST_SLEEP || irq_hit) meas_active_reg <= 1'b0;
         else if (launch) meas_active_reg <= 1'b1;
         else if (adc_done) meas_active_reg <= 1'b0;
      end
   end

   // registered outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwr_ctl <= psm_pwr_s'(`PSM_PWR_RESET);
         adc_ctl <= '0;
         interrupt_out_n <= 1'b1;
      end else if (clk_en) begin
         pwr_ctl <= pwr_next;
         adc_ctl <= adc_next;
         interrupt_out_n <= ~irq_hit;
      end
   end

   // checks; a frozen clock enable holds every relation still
   default clocking chk_cb @(posedge pclk iff clk_en);
   endclocking
   default disable iff (!presetn);

   sequence seq_clean_entry;
      (state_reg == ST_ENTER && enter_step_reg == 2'd0 && !irq_hit) ##1 (!irq_hit) [*2];
   endsequence

   sequence seq_cmd_rejected;
      go_cmd && irq_hit;
   endsequence

   chk_reject_pending: assert property (seq_cmd_rejected |=> state_reg == ST_ACTIVE)
      else $error("command taken with enabled interrupt pending");
   chk_start_on_csn: assert property (
      (state_reg == ST_ACTIVE && !csn_rise) |=> state_reg != ST_ENTER)
      else $error("entry started without chip select rise");
   chk_entry_sequence: assert property (seq_clean_entry |=> state_reg == ST_SLEEP)
      else $error("entry did not reach sleep in three steps");
   chk_sleep_clock: assert property (
      (state_reg == ST_SLEEP && $past(state_reg) == ST_SLEEP) |->
      pwr_ctl.slow_osc_clock_sel && !pwr_ctl.divided_clock_en && !pwr_ctl.host_clk_en)
      else $error("clocks not gated in sleep");
   chk_wake_on_irq: assert property ((state_reg == ST_SLEEP && irq_hit) |=> state_reg == ST_WAKE)
      else $error("enabled interrupt did not wake");
   chk_wake_host_clk: assert property (state_reg == ST_WAKE |=> !pwr_ctl.host_clk_en)
      else $error("host clock back before settling");
   chk_ultra_rails: assert property (
      (state_reg == ST_SLEEP && tgt_reg == TGT_ULTRA) |=>
      !pwr_ctl.supply_off_indicator_n && !pwr_ctl.io_supply_rail)
      else $error("rails or indicator wrong in ultra low power");
   chk_abort_invalid: assert property (
      (state_reg == ST_ENTER && enter_step_reg == 2'd0 && irq_hit) |=> !valid_reg)
      else $error("aborted entry left timer valid");
   chk_irq_output: assert property (interrupt_out_n == !$past(irq_hit))
      else $error("interrupt output does not follow enabled status");
   chk_timer_frozen: assert property (
      (state_reg == ST_ACTIVE && $past(state_reg) == ST_ACTIVE) |-> $stable(nap_count_reg))
      else $error("nap timer moved in full power");
   chk_active_restore: assert property (
      (state_reg == ST_ACTIVE && $past(state_reg) == ST_ACTIVE) |->
      pwr_ctl.cur_adc_en == $past(act_cfg_reg[`PSM_ACT_CUR_BIT]))
      else $error("active converter setting not applied");

endmodule

`default_nettype wire

/* File: verif/psm_adc_model.sv */
// behavioural ADC unit that answers start pulses of the power manager
`timescale 1ns/1ps
`default_nettype none

module psm_adc_model
   import psm_pkg::*;
(
   input  wire logic     pclk,
   input  wire psm_adc_s adc_ctl,
   output var  logic     adc_done
);
   int cnt = 0;

   initial adc_done = 1'b0;

   // conversion takes a few cycles; done comes back as a one-cycle pulse
   always @(posedge pclk) begin
      adc_done <= (cnt == 1);
      if (adc_ctl.start)
         cnt <= 6;
      else if (cnt > 0)
         cnt <= cnt - 1;
   end
endmodule

`default_nettype wire

/* File: verif/tb.sv */
// self-checking bench of the power state manager
`timescale 1ns/1ps
`default_nettype none
`include "psm_cfg.svh"

module tb
   import psm_pkg::*;
;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, spi_csn = 1;
   logic        clk_en = 1;
   logic [7:0]  paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd, keep;
   logic        pready, pslverr, err, adc_done, interrupt_out_n, nap_timer_expired;
   logic [15:0] irq_status = 0;
   logic [4:0]  acfg, rev;
   logic [7:0]  scfg;
   psm_pwr_s    pwr_ctl;
   psm_adc_s    adc_ctl;
   int          n_fail = 0, tests_run = 0, seed = 51723, i, w;

   // 10 MHz bus clock
   always #50 pclk = ~pclk;

   // short nap tick keeps the run brief
   psm_power_state_manager #(.NAP_TICK_CYCLES(8)) dut (
      .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .spi_csn(spi_csn), .irq_status(irq_status), .adc_done(adc_done),
      .pwr_ctl(pwr_ctl), .adc_ctl(adc_ctl), .interrupt_out_n(interrupt_out_n),
      .nap_timer_expired(nap_timer_expired)
   );

   psm_adc_model adc (.pclk(pclk), .adc_ctl(adc_ctl), .adc_done(adc_done));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // one APB transfer; waits for pready, never assumes its latency
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      // only the watchdog ends a wait for the answer
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // rails, indicator and LIN receiver in each sleep target
   function automatic logic [3:0] exp_rails(input int t);
      return (t < 2) ? 4'b1111 : 4'b0001;
   endfunction

   // hang guard, well beyond the expected few thousand cycles
   initial begin
      cyc(20000);
      n_fail++;
      complete_run();
   end

   initial begin
      cyc(2);
      presetn <= 1;
      chk(32'(pwr_ctl), `PSM_PWR_RESET);
      apb(0, `PSM_OFS_SLP_CFG, 0);
      chk(rd, `PSM_SLP_CFG_RESET);
      apb(0, 8'h40, 0);
      chk(err, 1);
      apb(1, `PSM_OFS_IRQ_ENA, 32'h0000_0002);
      apb(1, `PSM_OFS_NAP_CMP, 32'h0000_0002);
      irq_status <= 16'h0004;
      cyc(3);
      chk(interrupt_out_n, 1);
      irq_status <= 16'h0002;
      cyc(3);
      chk(interrupt_out_n, 0);
      // pending enabled irq at the command must refuse it
      spi_csn <= 0;
      apb(1, `PSM_OFS_SLP_CMD, `PSM_SLEEP_CMD);
      spi_csn <= 1;
      cyc(20);
      chk(pwr_ctl.host_clk_en, 1);
      apb(0, `PSM_OFS_STATUS, 0);
      chk(rd[0], 0);
      irq_status <= 0;
      // every target, random active and sleep settings, plan none
      for (i = 0; i < 4; i++) begin
         acfg = 5'($random(seed));
         scfg = 8'($random(seed));
         scfg[4:0] = 5'(i);
         apb(1, `PSM_OFS_ACT_CFG, 32'(acfg));
         apb(1, `PSM_OFS_SLP_CFG, 32'(scfg));
         spi_csn <= 0;
         apb(1, `PSM_OFS_SLP_CMD, `PSM_SLEEP_CMD);
         cyc(20);
         chk(pwr_ctl.host_clk_en, 1);
         spi_csn <= 1;
         while (pwr_ctl.slow_osc_clock_sel !== 1'b1)
            cyc(1);
         chk(nap_timer_expired, 0);
         cyc(40);
         chk({pwr_ctl.host_clk_en, pwr_ctl.hp_osc_en, pwr_ctl.lin_tx_en,
              pwr_ctl.divided_clock_en}, 0);
         chk({pwr_ctl.io_supply_rail, pwr_ctl.core_supply_rail,
              pwr_ctl.supply_off_indicator_n, pwr_ctl.lin_rx_en}, exp_rails(i));
         if (i == 3)
            chk(pwr_ctl.analog_en, 0);
         chk({pwr_ctl.cur_adc_en, pwr_ctl.volt_adc_en, adc_ctl.pmu_owns}, 1);
         chk({pwr_ctl.bias_cut_small, pwr_ctl.bias_cut_large, pwr_ctl.offcancel_off},
             {scfg[5], scfg[6], ~scfg[7]});
         chk(nap_timer_expired, 1);
         // wake: host clock only after the stabilisation wait
         irq_status <= 16'h0002;
         w = 0;
         while (pwr_ctl.host_clk_en !== 1'b1) begin
            cyc(1);
            w++;
         end
         chk(w >= 1000, 1);
         rev = {<<{acfg}};
         chk(pwr_ctl[4:0], rev);
         chk({pwr_ctl.divided_clock_en, pwr_ctl.slow_osc_clock_sel}, 2'b10);
         irq_status <= 0;
         apb(0, `PSM_OFS_NAP_COUNT, 0);
         keep = rd;
         chk(keep, 32'h0000_0002);
         cyc(20);
         apb(0, `PSM_OFS_NAP_COUNT, 0);
         chk(rd, keep);
         apb(0, `PSM_OFS_STATUS, 0);
         chk(rd[1], 1);
         $display("target %0d done", i);
      end
      // discrete current plan: converter powered only inside a window
      apb(1, `PSM_OFS_ACT_CFG, 0);
      apb(1, `PSM_OFS_TRIG_CMP, 32'h0000_0001);
      apb(1, `PSM_OFS_SLP_CFG, 32'h0000_0024);
      spi_csn <= 0;
      apb(1, `PSM_OFS_SLP_CMD, `PSM_SLEEP_CMD);
      spi_csn <= 1;
      while (pwr_ctl.cur_adc_en !== 1'b1)
         cyc(1);
      chk(pwr_ctl.volt_adc_en, 0);
      chk({adc_ctl.pmu_owns, adc_ctl.mode}, 4'h9);
      while (pwr_ctl.cur_adc_en !== 1'b0)
         cyc(1);
      chk(pwr_ctl.slow_osc_clock_sel, 1);
      irq_status <= 16'h0002;
      while (pwr_ctl.host_clk_en !== 1'b1)
         cyc(1);
      irq_status <= 0;
      chk(pwr_ctl.cur_adc_en, 0);
      $display("measure plan done");
      // interrupt in the first entry step undoes the entry
      spi_csn <= 0;
      apb(1, `PSM_OFS_SLP_CMD, `PSM_SLEEP_CMD);
      spi_csn <= 1;
      cyc(3);
      irq_status <= 16'h0002;
      cyc(3);
      chk(pwr_ctl.host_clk_en, 0);
      apb(0, `PSM_OFS_STATUS, 0);
      chk(rd[6:4], 3'h3);
      chk(rd[1], 0);
      irq_status <= 0;
      while (pwr_ctl.host_clk_en !== 1'b1)
         cyc(1);
      chk(pwr_ctl.supply_off_indicator_n, 1);
      $display("aborted entry done");
      // second reset in mid-run, then a frozen clock enable holds state
      apb(1, `PSM_OFS_ACT_CFG, 32'h0000_001F);
      presetn <= 0;
      cyc(2);
      presetn <= 1;
      chk(32'(pwr_ctl), `PSM_PWR_RESET);
      apb(0, `PSM_OFS_ACT_CFG, 0);
      chk(rd, `PSM_ACT_CFG_RESET);
      apb(1, `PSM_OFS_IRQ_ENA, 32'h0000_0002);
      clk_en <= 0;
      irq_status <= 16'h0002;
      cyc(3);
      chk(interrupt_out_n, 1);
      clk_en <= 1;
      cyc(3);
      chk(interrupt_out_n, 0);
      irq_status <= 0;
      $display("reset and freeze done");
      complete_run();
   end
endmodule

`default_nettype wire
